// ==== hdl/iop_map.svh ====
// Register indices, field values and reset values of the input port block
`ifndef IOP_MAP_SVH
`define IOP_MAP_SVH

// Register indices; byte address is four times the index
`define IOP_WIDE_IDX 16'hFFDE
`define IOP_NARROW_IDX 16'hFFDF
`define IOP_CONV_IDX 16'hFFC4

// Address slicing of the bus address
`define IOP_ADDR_W 18
`define IOP_IDX_HI 17
`define IOP_IDX_LO 2

// Channel select field and its byte lane inside the converter word
`define IOP_SEL_MSB 3
`define IOP_SEL_LSB 0
`define IOP_SEL_LANE 0

// Fixed fill of the unused upper nibble of the narrow port word
`define IOP_NARROW_FILL 4'hF

// Channel codes: narrow pins take codes 0 to 3, wide pins 4 to 11
`define IOP_NARROW_CH_BASE 4'h0
`define IOP_WIDE_CH_BASE 4'h4

// Channel select after reset: code 15 claims no port pin
`define IOP_CONV_RESET 4'hF

// Bus answers
`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2

`endif

// ==== hdl/iop_pkg.sv ====
// Types shared by the input port block
package iop_pkg;

    typedef struct packed {
        logic [7:0] wide;
        logic [3:0] narrow;
    } iop_pins_t;

    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [15:0] aw_idx;
        logic [3:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] chan_sel;
    } iop_state_t;

endpackage : iop_pkg

// ==== hdl/iop_input_port_read.sv ====
// Input-only port read logic with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "iop_map.svh"

module iop_input_port_read
    import iop_pkg::*;
#(
    parameter int WIDE_W = 8,
    parameter int NARROW_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire iop_pins_t pins,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`IOP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`IOP_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    // ------------------------------------------------------------
    // Analog claim masks
    // ------------------------------------------------------------
    iop_state_t s_q;
    iop_state_t s_d;
    logic [WIDE_W-1:0] wide_mask;
    logic [NARROW_W-1:0] narrow_mask;

    generate
        for (genvar i = 0; i < WIDE_W; i++) begin : g_wide
            assign wide_mask[i] = (s_q.chan_sel == (`IOP_WIDE_CH_BASE + 4'(i)));
        end
        for (genvar j = 0; j < NARROW_W; j++) begin : g_narrow
            assign narrow_mask[j] = (s_q.chan_sel == (`IOP_NARROW_CH_BASE + 4'(j)));
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic [15:0] ar_idx;

    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[`IOP_IDX_HI:`IOP_IDX_LO];

    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (aw_fire) begin
            s_d.aw_held = 1'b1;
            s_d.aw_idx = s_axi_awaddr[`IOP_IDX_HI:`IOP_IDX_LO];
        end
        if (w_fire) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata[`IOP_SEL_MSB:`IOP_SEL_LSB];
            s_d.w_lane0 = s_axi_wstrb[`IOP_SEL_LANE];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Complete a write once address and data are both in
        if (s_d.aw_held && s_d.w_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            case (s_d.aw_idx)
                `IOP_CONV_IDX: begin
                    if (s_d.w_lane0) begin
                        s_d.chan_sel = s_d.w_data;
                    end
                    s_d.bresp = `IOP_RESP_OKAY;
                end
                `IOP_WIDE_IDX, `IOP_NARROW_IDX: begin
                    s_d.bresp = `IOP_RESP_OKAY;
                end
                default: begin
                    s_d.bresp = `IOP_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        // Reads sample the pins in the cycle the address is taken
        if (ar_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `IOP_RESP_OKAY;
            case (ar_idx)
                `IOP_WIDE_IDX: begin
                    s_d.rdata = {24'h000000, pins.wide & ~wide_mask};
                end
                `IOP_NARROW_IDX: begin
                    s_d.rdata = {24'h000000, `IOP_NARROW_FILL,
                                 pins.narrow & ~narrow_mask};
                end
                `IOP_CONV_IDX: begin
                    s_d.rdata = {28'h0000000, s_q.chan_sel};
                end
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = `IOP_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.chan_sel <= `IOP_CONV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [2:0] wide_pick;
    logic [1:0] narrow_pick;
    logic chan_is_wide;
    logic chan_is_narrow;

    assign chan_is_wide = wide_mask != '0;
    assign chan_is_narrow = narrow_mask != '0;
    assign wide_pick = 3'(s_q.chan_sel - `IOP_WIDE_CH_BASE);
    assign narrow_pick = 2'(s_q.chan_sel - `IOP_NARROW_CH_BASE);

    property p_wide_upper_zero;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && ar_idx == `IOP_WIDE_IDX |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_wide_upper_zero: assert property (p_wide_upper_zero)
        else $error("wide port read carries bits above the port");

    property p_wide_live;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && ar_idx == `IOP_WIDE_IDX && !chan_is_wide
            |=> s_axi_rdata[7:0] == $past(pins.wide) && s_axi_rresp == `IOP_RESP_OKAY;
    endproperty
    a_wide_live: assert property (p_wide_live)
        else $error("wide port read does not return pin levels");

    property p_wide_analog_zero;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && ar_idx == `IOP_WIDE_IDX && chan_is_wide && pins.wide[wide_pick]
            |=> s_axi_rdata[$past(wide_pick)] == 1'b0;
    endproperty
    a_wide_analog_zero: assert property (p_wide_analog_zero)
        else $error("analog wide pin did not read zero");

    property p_narrow_upper;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && ar_idx == `IOP_NARROW_IDX
            |=> s_axi_rdata[31:4] == {24'h000000, `IOP_NARROW_FILL};
    endproperty
    a_narrow_upper: assert property (p_narrow_upper)
        else $error("narrow port upper bits wrong");

    property p_narrow_live;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && ar_idx == `IOP_NARROW_IDX && !chan_is_narrow
            |=> s_axi_rdata[3:0] == $past(pins.narrow);
    endproperty
    a_narrow_live: assert property (p_narrow_live)
        else $error("narrow port read does not return pin levels");

    property p_narrow_analog_zero;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && ar_idx == `IOP_NARROW_IDX && chan_is_narrow && pins.narrow[narrow_pick]
            |=> s_axi_rdata[$past(narrow_pick)] == 1'b0;
    endproperty
    a_narrow_analog_zero: assert property (p_narrow_analog_zero)
        else $error("analog narrow pin did not read zero");

    property p_port_write_ignored;
        @(posedge aclk) disable iff (!aresetn)
        $rose(s_axi_bvalid) && s_q.aw_idx != `IOP_CONV_IDX |-> $stable(s_q.chan_sel);
    endproperty
    a_port_write_ignored: assert property (p_port_write_ignored)
        else $error("write to a port register changed state");

    property p_read_held;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_read_held: assert property (p_read_held)
        else $error("read answer dropped before taken");

endmodule : iop_input_port_read

// ==== testbench/iop_axi_master.sv ====
// AXI4-Lite master model standing in for the processor core
`timescale 1ns/1ps
`include "iop_map.svh"

module iop_axi_master (
    input wire logic aclk,
    output logic awvalid,
    input wire logic awready,
    output logic [`IOP_ADDR_W-1:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [`IOP_ADDR_W-1:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    logic [3:0] wr_strobe = 4'hF;

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, wstrb, araddr} = '0;
    end

    task automatic write(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= wr_strobe;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : write

    task automatic read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : read
endmodule : iop_axi_master

// ==== testbench/input_only_port_read_test.sv ====
// Self-checking bench of the input-only port read block
`timescale 1ns/1ps
`include "iop_map.svh"

module input_only_port_read_test
    import iop_pkg::*;
;
    localparam logic [17:0] A_WIDE = {`IOP_WIDE_IDX, 2'h0};
    localparam logic [17:0] A_NARROW = {`IOP_NARROW_IDX, 2'h0};
    localparam logic [17:0] A_CONV = {`IOP_CONV_IDX, 2'h0};
    localparam logic [17:0] A_NONE = 18'h00010;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    iop_pins_t pins = '0;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;

    iop_axi_master i_iop_axi_master (.aclk(aclk), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp));

    iop_input_port_read i_iop_input_port_read (.aclk(aclk), .aresetn(aresetn), .pins(pins),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));

    initial begin
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rd_chk(input string n, input logic [17:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        i_iop_axi_master.read(a, data, resp);
        chk(n, e, data);
        chk({n, " resp"}, {30'h0, er}, {30'h0, resp});
    endtask : rd_chk

    task automatic wr_chk(input string n, input logic [17:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        i_iop_axi_master.write(a, d, resp);
        chk({n, " resp"}, {30'h0, er}, {30'h0, resp});
    endtask : wr_chk

    task automatic t_reset_live();
        pins <= {8'hC3, 4'h6};
        rd_chk("select", A_CONV, {28'h0, `IOP_CONV_RESET}, `IOP_RESP_OKAY);
        rd_chk("wide", A_WIDE, 32'h000000C3, `IOP_RESP_OKAY);
        rd_chk("narrow", A_NARROW, {24'h0, `IOP_NARROW_FILL, 4'h6}, `IOP_RESP_OKAY);
        pins <= {8'h5A, 4'h9};
        rd_chk("wide", A_WIDE, 32'h0000005A, `IOP_RESP_OKAY);
        rd_chk("narrow", A_NARROW, {24'h0, `IOP_NARROW_FILL, 4'h9}, `IOP_RESP_OKAY);
    endtask : t_reset_live

    task automatic t_analog_claim();
        logic [7:0] ew;
        logic [3:0] en;
        pins <= '1;
        for (int c = 0; c < 16; c++) begin
            ew = 8'hFF;
            en = 4'hF;
            if (c >= `IOP_WIDE_CH_BASE && c < 12) ew[c - `IOP_WIDE_CH_BASE] = 1'b0;
            if (c < `IOP_WIDE_CH_BASE) en[c] = 1'b0;
            wr_chk("select wr", A_CONV, 32'(c), `IOP_RESP_OKAY);
            rd_chk("select", A_CONV, 32'(c), `IOP_RESP_OKAY);
            rd_chk("wide", A_WIDE, {24'h0, ew}, `IOP_RESP_OKAY);
            rd_chk("narrow", A_NARROW, {24'h0, `IOP_NARROW_FILL, en}, `IOP_RESP_OKAY);
        end
    endtask : t_analog_claim

    task automatic t_writes_ignored();
        pins <= {8'h3C, 4'hA};
        wr_chk("select wr", A_CONV, 32'h0000000F, `IOP_RESP_OKAY);
        wr_chk("wide wr", A_WIDE, 32'h0, `IOP_RESP_OKAY);
        wr_chk("narrow wr", A_NARROW, 32'h0, `IOP_RESP_OKAY);
        rd_chk("wide", A_WIDE, 32'h0000003C, `IOP_RESP_OKAY);
        rd_chk("narrow", A_NARROW, {24'h0, `IOP_NARROW_FILL, 4'hA}, `IOP_RESP_OKAY);
        rd_chk("unmapped", A_NONE, 32'h0, `IOP_RESP_SLVERR);
        wr_chk("unmapped wr", A_NONE, 32'h00000005, `IOP_RESP_SLVERR);
        i_iop_axi_master.wr_strobe = 4'h0;
        wr_chk("masked select wr", A_CONV, 32'h00000005, `IOP_RESP_OKAY);
        i_iop_axi_master.wr_strobe = 4'hF;
        rd_chk("select", A_CONV, 32'h0000000F, `IOP_RESP_OKAY);
    endtask : t_writes_ignored

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_live();
        t_analog_claim();
        t_writes_ignored();
        test_done();
    end
endmodule : input_only_port_read_test
